/* File: src/spfm_pkg.sv */
// constants for the shared pin function mux
package spfm_pkg;
  localparam int          PIN_COUNT       = 16;
  localparam int          VEC_WIDTH       = 4;
  localparam int          BIO_WIDTH       = 8;
  localparam int          HOST_DATA_WIDTH = 8;
  localparam int          HOST_CTL_WIDTH  = 4;
  localparam int          SER_WIDTH       = 8;
  localparam int          IOC_WIDTH       = 16;
  localparam int          UPPER_BIT_POS   = 12;
  localparam int          SERIAL_BIT_POS  = 10;
  localparam int          VEC_PIN_BASE    = 0;
  localparam int          DATA_PIN_BASE   = 4;
  localparam int          CTL_PIN_BASE    = 12;
  localparam logic        SEL_RESET       = 1'b0;
  localparam logic        PIN_RESET       = 1'b0;
endpackage : spfm_pkg

/* File: src/spfm_pin_slice.sv */
// registered two-way selector for a bank of shared pins
`timescale 1ns/1ps
module spfm_pin_slice #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] sel,
  input  wire logic [W-1:0] dflt_out,
  input  wire logic [W-1:0] dflt_oe,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] alt_oe,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out_q,
  output logic      [W-1:0] pin_oe_q,
  output logic      [W-1:0] dflt_in_q,
  output logic      [W-1:0] alt_in_q
);
  logic [W-1:0] pin_out_d;
  logic [W-1:0] pin_oe_d;
  logic [W-1:0] dflt_in_d;
  logic [W-1:0] alt_in_d;

  // one owner per pin, the other side sees zero
  always_comb begin
    pin_out_d = (sel & alt_out) | (~sel & dflt_out);
    pin_oe_d  = (sel & alt_oe) | (~sel & dflt_oe);
    dflt_in_d = ~sel & pin_in;
    alt_in_d  = sel & pin_in;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_q <= '0;
      pin_oe_q  <= '0;
      dflt_in_q <= '0;
      alt_in_q  <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      dflt_in_q <= dflt_in_d;
      alt_in_q  <= alt_in_d;
    end
  end
endmodule : spfm_pin_slice

/* File: src/spfm_shared_pin_mux.sv */
// shared pin function mux top
`timescale 1ns/1ps
module spfm_shared_pin_mux
  import spfm_pkg::*;
(
  input  wire logic                       CLK,
  input  wire logic                       RST_B,
  input  wire logic                       IOC_WE,
  input  wire logic [IOC_WIDTH-1:0]       IOC_WDATA,
  output logic                            UPPER_BITIO_SELECT,
  output logic                            SECOND_SERIAL_SELECT,
  input  wire logic [VEC_WIDTH-1:0]       INTERRUPT_VECTOR_CODE,
  input  wire logic [BIO_WIDTH-1:0]       BIT_IO_LINES_OUT,
  input  wire logic [BIO_WIDTH-1:0]       BIT_IO_LINES_OE,
  output logic      [BIO_WIDTH-1:0]       BIT_IO_LINES_IN,
  input  wire logic [HOST_DATA_WIDTH-1:0] HOST_DATA_OUT,
  input  wire logic [HOST_DATA_WIDTH-1:0] HOST_DATA_OE,
  output logic      [HOST_DATA_WIDTH-1:0] HOST_DATA_IN,
  input  wire logic [HOST_CTL_WIDTH-1:0]  HOST_CTL_OUT,
  input  wire logic [HOST_CTL_WIDTH-1:0]  HOST_CTL_OE,
  output logic      [HOST_CTL_WIDTH-1:0]  HOST_CTL_IN,
  input  wire logic [SER_WIDTH-1:0]       SERIAL_OUT,
  input  wire logic [SER_WIDTH-1:0]       SERIAL_OE,
  output logic      [SER_WIDTH-1:0]       SERIAL_IN,
  input  wire logic [PIN_COUNT-1:0]       PIN_IN,
  output logic      [PIN_COUNT-1:0]       PIN_OUT,
  output logic      [PIN_COUNT-1:0]       PIN_OE
);
  localparam int HALF_BIO = BIO_WIDTH / 2;

  logic                 upper_bitio_select_q;
  logic                 upper_bitio_select_d;
  logic                 second_serial_select_q;
  logic                 second_serial_select_d;
  logic [PIN_COUNT-1:0] pin_sel;
  logic [PIN_COUNT-1:0] dflt_out;
  logic [PIN_COUNT-1:0] dflt_oe;
  logic [PIN_COUNT-1:0] alt_out;
  logic [PIN_COUNT-1:0] alt_oe;
  logic [PIN_COUNT-1:0] dflt_in;
  logic [PIN_COUNT-1:0] alt_in;

  // selection bits captured from configuration writes
  always_comb begin
    upper_bitio_select_d   = upper_bitio_select_q;
    second_serial_select_d = second_serial_select_q;
    if (IOC_WE) begin
      upper_bitio_select_d   = IOC_WDATA[UPPER_BIT_POS];
      second_serial_select_d = IOC_WDATA[SERIAL_BIT_POS];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      upper_bitio_select_q   <= SEL_RESET;
      second_serial_select_q <= SEL_RESET;
    end else begin
      upper_bitio_select_q   <= upper_bitio_select_d;
      second_serial_select_q <= second_serial_select_d;
    end
  end

  assign UPPER_BITIO_SELECT   = upper_bitio_select_q;
  assign SECOND_SERIAL_SELECT = second_serial_select_q;

  // per-pin owner select
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_sel
      if (i < DATA_PIN_BASE) begin : g_vec
        assign pin_sel[i] = upper_bitio_select_q;
      end else begin : g_host
        assign pin_sel[i] = second_serial_select_q;
      end
    end
  endgenerate

  // default owners: vector code, host data, host control
  assign dflt_out[DATA_PIN_BASE-1:VEC_PIN_BASE] = INTERRUPT_VECTOR_CODE;
  assign dflt_oe[DATA_PIN_BASE-1:VEC_PIN_BASE]  = '1;
  assign dflt_out[CTL_PIN_BASE-1:DATA_PIN_BASE] = HOST_DATA_OUT;
  assign dflt_oe[CTL_PIN_BASE-1:DATA_PIN_BASE]  = HOST_DATA_OE;
  assign dflt_out[PIN_COUNT-1:CTL_PIN_BASE]     = HOST_CTL_OUT;
  assign dflt_oe[PIN_COUNT-1:CTL_PIN_BASE]      = HOST_CTL_OE;

  // alternates: upper bit i/o, serial on host bits 0-3, lower bit i/o on 4-7
  assign alt_out[DATA_PIN_BASE-1:VEC_PIN_BASE] = BIT_IO_LINES_OUT[BIO_WIDTH-1:HALF_BIO];
  assign alt_oe[DATA_PIN_BASE-1:VEC_PIN_BASE]  = BIT_IO_LINES_OE[BIO_WIDTH-1:HALF_BIO];
  assign alt_out[DATA_PIN_BASE+3:DATA_PIN_BASE] = SERIAL_OUT[3:0];
  assign alt_oe[DATA_PIN_BASE+3:DATA_PIN_BASE]  = SERIAL_OE[3:0];
  assign alt_out[CTL_PIN_BASE-1:DATA_PIN_BASE+4] = BIT_IO_LINES_OUT[HALF_BIO-1:0];
  assign alt_oe[CTL_PIN_BASE-1:DATA_PIN_BASE+4]  = BIT_IO_LINES_OE[HALF_BIO-1:0];
  assign alt_out[PIN_COUNT-1:CTL_PIN_BASE] = SERIAL_OUT[SER_WIDTH-1:4];
  assign alt_oe[PIN_COUNT-1:CTL_PIN_BASE]  = SERIAL_OE[SER_WIDTH-1:4];

  spfm_pin_slice #(
    .W (PIN_COUNT)
  ) u_slice (
    .clk       (CLK),
    .rst_b     (RST_B),
    .sel       (pin_sel),
    .dflt_out  (dflt_out),
    .dflt_oe   (dflt_oe),
    .alt_out   (alt_out),
    .alt_oe    (alt_oe),
    .pin_in    (PIN_IN),
    .pin_out_q (PIN_OUT),
    .pin_oe_q  (PIN_OE),
    .dflt_in_q (dflt_in),
    .alt_in_q  (alt_in)
  );

  // sampled pins back to their current owner; vector pins are output only
  assign HOST_DATA_IN = dflt_in[CTL_PIN_BASE-1:DATA_PIN_BASE];
  assign HOST_CTL_IN  = dflt_in[PIN_COUNT-1:CTL_PIN_BASE];
  assign BIT_IO_LINES_IN = {alt_in[DATA_PIN_BASE-1:VEC_PIN_BASE],
                            alt_in[CTL_PIN_BASE-1:DATA_PIN_BASE+4]};
  assign SERIAL_IN = {alt_in[PIN_COUNT-1:CTL_PIN_BASE],
                      alt_in[DATA_PIN_BASE+3:DATA_PIN_BASE]};
endmodule : spfm_shared_pin_mux

/* File: testbench/spfm_mux_sva.sv */
// checker for the shared pin function mux
`timescale 1ns/1ps
module spfm_mux_sva (
  input logic        CLK,
  input logic        RST_B,
  input logic        IOC_WE,
  input logic [15:0] IOC_WDATA,
  input logic        UPPER_BITIO_SELECT,
  input logic        SECOND_SERIAL_SELECT,
  input logic [3:0]  INTERRUPT_VECTOR_CODE,
  input logic [7:0]  BIT_IO_LINES_OUT,
  input logic [7:0]  HOST_DATA_OUT,
  input logic [7:0]  SERIAL_OUT,
  input logic [7:0]  SERIAL_IN,
  input logic [15:0] PIN_IN,
  input logic [15:0] PIN_OUT
);
  logic g_q, u_q, s_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) {g_q, u_q, s_q} <= 3'h0;
    else {g_q, u_q, s_q} <= {1'b1, UPPER_BITIO_SELECT, SECOND_SERIAL_SELECT};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_vec; g_q && !u_q |-> PIN_OUT[3:0] == $past(INTERRUPT_VECTOR_CODE); endproperty
  a_vec: assert property (p_vec) else $error("vector pins wrong");
  property p_up; g_q && u_q |-> PIN_OUT[3:0] == $past(BIT_IO_LINES_OUT[7:4]); endproperty
  a_up: assert property (p_up) else $error("upper bit pins wrong");
  property p_host; g_q && !s_q |-> PIN_OUT[11:4] == $past(HOST_DATA_OUT); endproperty
  a_host: assert property (p_host) else $error("host pins wrong");
  property p_ser; g_q && s_q |-> PIN_OUT[7:4] == $past(SERIAL_OUT[3:0]); endproperty
  a_ser: assert property (p_ser) else $error("serial pins wrong");
  property p_ick; g_q && s_q |-> SERIAL_IN[0] == $past(PIN_IN[4]); endproperty
  a_ick: assert property (p_ick) else $error("serial clock input wrong");
  property p_b2; g_q && s_q |-> PIN_OUT[10] == $past(BIT_IO_LINES_OUT[2]); endproperty
  a_b2: assert property (p_b2) else $error("bit line 2 pin wrong");
  property p_ld; IOC_WE |=> UPPER_BITIO_SELECT == $past(IOC_WDATA[12]); endproperty
  a_ld: assert property (p_ld) else $error("select load wrong");
  property p_lds; IOC_WE |=> SECOND_SERIAL_SELECT == $past(IOC_WDATA[10]); endproperty
  a_lds: assert property (p_lds) else $error("serial select load wrong");
  property p_hold; !IOC_WE |=> $stable({UPPER_BITIO_SELECT, SECOND_SERIAL_SELECT}); endproperty
  a_hold: assert property (p_hold) else $error("select moved");
endmodule : spfm_mux_sva
bind spfm_shared_pin_mux spfm_mux_sva spfm_mux_sva_inst (.*);

/* File: testbench/spfm_pad_model.sv */
// pad level model of the parties beyond the shared pins
`timescale 1ns/1ps
module spfm_pad_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext,
  output logic      [15:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : spfm_pad_model

/* File: testbench/spfm_shared_pin_mux_tb_top.sv */
// random and corner bench for the shared pin function mux
`timescale 1ns/1ps
module spfm_shared_pin_mux_tb_top;
  logic CLK = 0, RST_B = 0, IOC_WE = 0, UPPER_BITIO_SELECT, SECOND_SERIAL_SELECT, u = 0, s = 0;
  logic [15:0] IOC_WDATA = 0, PIN_IN, PIN_OUT, PIN_OE, ext = 0;
  logic [7:0]  BIT_IO_LINES_OUT = 0, BIT_IO_LINES_OE = 0, BIT_IO_LINES_IN, HOST_DATA_IN;
  logic [7:0]  HOST_DATA_OUT = 0, HOST_DATA_OE = 0, SERIAL_OUT = 0, SERIAL_OE = 0, SERIAL_IN;
  logic [3:0]  INTERRUPT_VECTOR_CODE = 0, HOST_CTL_OUT = 0, HOST_CTL_OE = 0, HOST_CTL_IN;
  logic [31:0] e_pin = 32'h000f_0000, e_in = 0;
  logic [15:0] wtab [6] = '{16'h1000, 16'h0400, 16'h1400, 16'h0000, 16'hebff, 16'hffff};
  integer      seed = 78, n_mismatch = 0, num_checks = 0, i;
  spfm_shared_pin_mux spfm_shared_pin_mux_inst (.*);
  spfm_pad_model spfm_pad_model_inst (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext(ext),
                                      .pin_in(PIN_IN));
  function automatic logic [15:0] mx(logic u, s, logic [3:0] v, c, logic [7:0] b, h, r);
    return {s ? r[7:4] : c, s ? b[3:0] : h[7:4], s ? r[3:0] : h[3:0], u ? b[7:4] : v};
  endfunction : mx
  task automatic chk(string n, logic [31:0] e, a);
    num_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, a);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial forever #2.5 CLK = ~CLK;
  initial begin
    #5000 n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(negedge CLK);
    chk("rst_pins", 32'h0, {PIN_OE, PIN_OUT});
    RST_B = 1;
    for (i = 0; i < 400; i++) begin
      @(negedge CLK);
      chk("pins", e_pin, {PIN_OE, PIN_OUT});
      chk("ins", e_in, {BIT_IO_LINES_IN, SERIAL_IN, HOST_DATA_IN, HOST_CTL_IN});
      chk("sel", {u, s}, {UPPER_BITIO_SELECT, SECOND_SERIAL_SELECT});
      {INTERRUPT_VECTOR_CODE, HOST_CTL_OUT, HOST_CTL_OE, BIT_IO_LINES_OUT} = 20'($random(seed));
      {HOST_DATA_OUT, HOST_DATA_OE, SERIAL_OUT, SERIAL_OE} = $random(seed);
      {ext, BIT_IO_LINES_OE} = 24'($random(seed));
      IOC_WE = 1'($random(seed));
      IOC_WDATA = i < 60 ? wtab[i / 10] : 16'($random(seed));
      e_pin = {mx(u, s, 4'hf, HOST_CTL_OE, BIT_IO_LINES_OE, HOST_DATA_OE, SERIAL_OE),
               mx(u, s, INTERRUPT_VECTOR_CODE, HOST_CTL_OUT, BIT_IO_LINES_OUT, HOST_DATA_OUT,
                  SERIAL_OUT)};
      #1 e_in = {4'h0, u ? PIN_IN[3:0] : 4'h0,
                 s ? {PIN_IN[11:8], PIN_IN[15:12], PIN_IN[7:4], 12'h0}
                   : {12'h0, PIN_IN[11:4], PIN_IN[15:12]}};
      if (IOC_WE) {u, s} = {IOC_WDATA[12], IOC_WDATA[10]};
    end
    tally_and_finish;
  end
endmodule : spfm_shared_pin_mux_tb_top
